/* File: sre_map.svh */
// sre_map.svh: opcodes, flag positions, cycle counts and reset values
// assumes: included by the instruction executer files, no other context
`ifndef SRE_MAP_SVH
`define SRE_MAP_SVH
`define SRE_OP_POP_DEC 8'h92
`define SRE_OP_POP_INC 8'h93
`define SRE_OP_PUSH_DIR 8'h70
`define SRE_OP_PUSH_IND 8'h71
`define SRE_OP_PUSH_DEC 8'h82
`define SRE_OP_PUSH_INC 8'h83
`define SRE_OP_CARRY_CLR 8'hCF
`define SRE_OP_RETURN 8'hAF
`define SRE_OP_ROT_DIR 8'h90
`define SRE_OP_ROT_IND 8'h91
`define SRE_FLAG_C 7
`define SRE_FLAG_Z 6
`define SRE_FLAG_S 5
`define SRE_FLAG_V 4
`define SRE_CYC_STACK 8
`define SRE_CYC_RET_EXT 10
`define SRE_CYC_SHORT 4
`define SRE_RST_BYTE 8'h00
`define SRE_RST_WORD 16'h0000
`endif

/* File: sre_pkg.sv */
// sre_pkg.sv: types shared by the stack and rotate executer
// assumes: constants come from sre_map.svh
package sre_pkg;
    typedef enum logic [2:0] {
        SRE_IDLE = 3'b000,
        SRE_READ = 3'b001,
        SRE_WRITE = 3'b010,
        SRE_WAIT = 3'b011,
        SRE_DONE = 3'b100
    } sre_state_type;
    // register file access request
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sre_rf_req_type;
    // system stack access request
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sre_stk_req_type;
endpackage : sre_pkg

/* File: sre_rotate.sv */
// sre_rotate.sv: plain rotate left with its flag results
// assumes: pure combinational, fed from the executer's register file read data
`timescale 1ns/1ns
module sre_rotate (
    input wire logic [7:0] operand, // destination byte before rotate
    output logic [7:0] result, // rotated byte
    output logic carry_out, // old bit 7
    output logic zero_out, // result is zero
    output logic sign_out, // result bit 7
    output logic ovf_out // sign changed by the rotate
);
    // bit 7 goes to bit 0 and to carry
    always_comb begin
        result = {operand[6:0], operand[7]};
        carry_out = operand[7];
        zero_out = (result == 8'h00);
        sign_out = result[7];
        ovf_out = result[7] ^ operand[7];
    end
endmodule : sre_rotate

/* File: sre_exec.sv */
// sre_exec.sv: executes user stack, system push, return, carry clear, rotate
// assumes: register file and stack memory answer reads in the same cycle
// Functional notes
// - decrementing user pop 92 copies byte at pointer, then pointer minus one.
// - incrementing user pop 93 copies byte at pointer, then pointer plus one.
// - system push 70/71 decrements stack pointer, then writes source there.
// - stack pointer is sixteen bits; zero minus one wraps to all ones.
// - decrementing user push 82 lowers pointer, then stores source there.
// - incrementing user push 83 raises pointer, then stores source there.
// - stack, push and return instructions leave all flags unchanged.
// - carry clear CF forces carry zero, other flags kept, four cycles.
// - return AF loads program counter from stack, stack pointer plus two.
// - first stacked byte is counter high half, next byte the low half.
// - rotate left 90/91 moves old bit 7 into bit 0 and carry.
// - rotate sets zero, sign, overflow; decimal and half carry kept.
// - rotate overflow means destination sign changed by the rotation.
`timescale 1ns/1ns
`include "sre_map.svh"
module sre_exec (
    input wire logic clk, // 10 MHz core clock
    input wire logic sys_rst, // synchronous active high reset
    input wire logic start, // pulse: opcode and operands valid
    input wire logic [7:0] opcode, // instruction opcode
    input wire logic [7:0] op_a, // first operand byte
    input wire logic [7:0] op_b, // second operand byte
    input wire logic ext_stack, // stack lies in external memory
    output logic busy, // instruction in progress
    output logic done, // pulse: instruction finished
    output logic illegal, // pulse: opcode not handled here
    output sre_pkg::sre_rf_req_type rf_req, // register file access
    input wire logic [7:0] rf_rdata, // register file read data
    output sre_pkg::sre_stk_req_type stk_req, // stack memory access
    input wire logic [7:0] stk_rdata, // stack memory read data
    output logic [15:0] sp_out, // system stack pointer
    output logic [15:0] pc_out, // program counter
    output logic pc_load, // pulse: program counter reloaded
    input wire logic [7:0] flags_in, // flags before instruction
    output logic [7:0] flags_out // flags after instruction
);
    ////////////////////////////////////////////////////////////////////
    sre_pkg::sre_state_type state_reg, state_next;
    logic [7:0] op_reg, op_next;
    logic [7:0] a_reg, a_next;
    logic [7:0] b_reg, b_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] data_reg, data_next;
    logic [15:0] sp_reg, sp_next;
    logic [15:0] pc_reg, pc_next;
    logic [7:0] flags_reg, flags_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [3:0] step_reg, step_next;
    logic done_reg, done_next;
    logic ill_reg, ill_next;
    logic load_reg, load_next;
    sre_pkg::sre_rf_req_type rf_q, rf_d;
    sre_pkg::sre_stk_req_type stk_q, stk_d;
    logic [7:0] rot_res;
    logic rot_c, rot_z, rot_s, rot_v;

    ////////////////////////////////////////////////////////////////////
    // rotate datapath on the fetched destination byte
    sre_rotate u_rot (
        .operand(rf_rdata),
        .result(rot_res),
        .carry_out(rot_c),
        .zero_out(rot_z),
        .sign_out(rot_s),
        .ovf_out(rot_v)
    );

    ////////////////////////////////////////////////////////////////////
    // next state of the execution sequence
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        a_next = a_reg;
        b_next = b_reg;
        ptr_next = ptr_reg;
        data_next = data_reg;
        sp_next = sp_reg;
        pc_next = pc_reg;
        flags_next = flags_reg;
        cnt_next = cnt_reg;
        step_next = step_reg;
        done_next = 1'b0;
        ill_next = 1'b0;
        load_next = 1'b0;
        rf_d = '0;
        stk_d = '0;
        case (state_reg)
            sre_pkg::SRE_IDLE: begin
                if (start) begin
                    op_next = opcode;
                    a_next = op_a;
                    b_next = op_b;
                    flags_next = flags_in;
                    step_next = 4'h0;
                    state_next = sre_pkg::SRE_READ;
                    // total instruction length in clocks
                    if (opcode == `SRE_OP_CARRY_CLR ||
                        opcode == `SRE_OP_ROT_DIR ||
                        opcode == `SRE_OP_ROT_IND) begin
                        cnt_next = 4'(`SRE_CYC_SHORT - 1);
                    end else if (opcode == `SRE_OP_RETURN && ext_stack) begin
                        cnt_next = 4'(`SRE_CYC_RET_EXT - 1);
                    end else begin
                        cnt_next = 4'(`SRE_CYC_STACK - 1);
                    end
                    if (opcode != `SRE_OP_POP_DEC &&
                        opcode != `SRE_OP_POP_INC &&
                        opcode != `SRE_OP_PUSH_DIR &&
                        opcode != `SRE_OP_PUSH_IND &&
                        opcode != `SRE_OP_PUSH_DEC &&
                        opcode != `SRE_OP_PUSH_INC &&
                        opcode != `SRE_OP_CARRY_CLR &&
                        opcode != `SRE_OP_RETURN &&
                        opcode != `SRE_OP_ROT_DIR &&
                        opcode != `SRE_OP_ROT_IND) begin
                        ill_next = 1'b1;
                        state_next = sre_pkg::SRE_IDLE;
                    end
                end
            end
            sre_pkg::SRE_READ: begin
                cnt_next = cnt_reg - 4'h1;
                step_next = step_reg + 4'h1;
                state_next = sre_pkg::SRE_WAIT;
                case (op_reg)
                    `SRE_OP_POP_DEC, `SRE_OP_POP_INC: begin
                        // op_a = destination, op_b = pointer register
                        if (step_reg == 4'h0) begin
                            rf_d.addr = b_reg;
                            ptr_next = rf_rdata;
                            state_next = sre_pkg::SRE_READ;
                        end else if (step_reg == 4'h1) begin
                            rf_d.addr = ptr_reg;
                            data_next = rf_rdata;
                            state_next = sre_pkg::SRE_READ;
                        end else if (step_reg == 4'h2) begin
                            rf_d = '{1'b1, a_reg, data_reg};
                            state_next = sre_pkg::SRE_READ;
                        end else begin
                            rf_d.we = 1'b1;
                            rf_d.addr = b_reg;
                            if (op_reg == `SRE_OP_POP_DEC) begin
                                rf_d.wdata = ptr_reg - 8'h01;
                            end else begin
                                rf_d.wdata = ptr_reg + 8'h01;
                            end
                        end
                    end
                    `SRE_OP_PUSH_DEC, `SRE_OP_PUSH_INC: begin
                        // op_a = pointer register, op_b = source
                        if (step_reg == 4'h0) begin
                            rf_d.addr = b_reg;
                            data_next = rf_rdata;
                            state_next = sre_pkg::SRE_READ;
                        end else if (step_reg == 4'h1) begin
                            rf_d.addr = a_reg;
                            if (op_reg == `SRE_OP_PUSH_DEC) begin
                                ptr_next = rf_rdata - 8'h01;
                            end else begin
                                ptr_next = rf_rdata + 8'h01;
                            end
                            state_next = sre_pkg::SRE_READ;
                        end else if (step_reg == 4'h2) begin
                            rf_d = '{1'b1, a_reg, ptr_reg};
                            state_next = sre_pkg::SRE_READ;
                        end else begin
                            rf_d = '{1'b1, ptr_reg, data_reg};
                        end
                    end
                    `SRE_OP_PUSH_DIR, `SRE_OP_PUSH_IND: begin
                        // op_a = source or register holding its address
                        if (step_reg == 4'h0) begin
                            rf_d.addr = a_reg;
                            data_next = rf_rdata;
                            sp_next = sp_reg - 16'h0001;
                            if (op_reg == `SRE_OP_PUSH_IND) begin
                                a_next = rf_rdata;
                                step_next = 4'h0;
                                op_next = `SRE_OP_PUSH_DIR;
                                sp_next = sp_reg;
                            end
                            state_next = sre_pkg::SRE_READ;
                        end else begin
                            stk_d = '{1'b1, sp_reg, data_reg};
                        end
                    end
                    `SRE_OP_RETURN: begin
                        if (step_reg == 4'h0) begin
                            stk_d.addr = sp_reg;
                            pc_next[15:8] = stk_rdata;
                            state_next = sre_pkg::SRE_READ;
                        end else begin
                            stk_d.addr = sp_reg + 16'h0001;
                            pc_next[7:0] = stk_rdata;
                            sp_next = sp_reg + 16'h0002;
                            load_next = 1'b1;
                        end
                    end
                    `SRE_OP_CARRY_CLR: begin
                        flags_next[`SRE_FLAG_C] = 1'b0;
                    end
                    default: begin
                        // rotate: direct register or register via pointer
                        rf_d.addr = a_reg;
                        if (op_reg == `SRE_OP_ROT_IND && step_reg == 4'h0) begin
                            a_next = rf_rdata;
                            state_next = sre_pkg::SRE_READ;
                        end else begin
                            data_next = rot_res;
                            flags_next[`SRE_FLAG_C] = rot_c;
                            flags_next[`SRE_FLAG_Z] = rot_z;
                            flags_next[`SRE_FLAG_S] = rot_s;
                            flags_next[`SRE_FLAG_V] = rot_v;
                            state_next = sre_pkg::SRE_WRITE;
                        end
                    end
                endcase
            end
            sre_pkg::SRE_WRITE: begin
                // store the rotated byte back; indirect form has no pad left
                cnt_next = cnt_reg - 4'h1;
                rf_d = '{1'b1, a_reg, data_reg};
                if (cnt_reg <= 4'h1) begin
                    state_next = sre_pkg::SRE_DONE;
                end else begin
                    state_next = sre_pkg::SRE_WAIT;
                end
            end
            sre_pkg::SRE_WAIT: begin
                // pad out to the documented cycle count
                if (cnt_reg <= 4'h1) begin
                    state_next = sre_pkg::SRE_DONE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: begin
                done_next = 1'b1;
                state_next = sre_pkg::SRE_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= sre_pkg::SRE_IDLE;
            op_reg <= `SRE_RST_BYTE;
            a_reg <= `SRE_RST_BYTE;
            b_reg <= `SRE_RST_BYTE;
            ptr_reg <= `SRE_RST_BYTE;
            data_reg <= `SRE_RST_BYTE;
            sp_reg <= `SRE_RST_WORD;
            pc_reg <= `SRE_RST_WORD;
            flags_reg <= `SRE_RST_BYTE;
            cnt_reg <= 4'h0;
            step_reg <= 4'h0;
            done_reg <= 1'b0;
            ill_reg <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            a_reg <= a_next;
            b_reg <= b_next;
            ptr_reg <= ptr_next;
            data_reg <= data_next;
            sp_reg <= sp_next;
            pc_reg <= pc_next;
            flags_reg <= flags_next;
            cnt_reg <= cnt_next;
            step_reg <= step_next;
            done_reg <= done_next;
            ill_reg <= ill_next;
            load_reg <= load_next;
        end
    end

    // memory requests are combinational handshakes, state is registered
    assign rf_q = rf_d;
    assign stk_q = stk_d;
    assign rf_req = rf_q;
    assign stk_req = stk_q;
    assign busy = (state_reg != sre_pkg::SRE_IDLE);
    assign done = done_reg;
    assign illegal = ill_reg;
    assign pc_load = load_reg;
    assign sp_out = sp_reg;
    assign pc_out = pc_reg;
    assign flags_out = flags_reg;

    ////////////////////////////////////////////////////////////////////
    // checks; done is registered, so an n-cycle instruction shows it
    // to the sampled value at the edge n+1 after the start edge
    a_carry_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        (start && !busy && opcode == `SRE_OP_CARRY_CLR) |->
        ##5 (done && !flags_out[`SRE_FLAG_C]))
        else $error("carry clear failed");
    a_stack_len: assert property (
        @(posedge clk) disable iff (sys_rst)
        (start && !busy && opcode == `SRE_OP_POP_DEC) |-> ##9 done)
        else $error("pop length wrong");
    a_ret_sp: assert property (
        @(posedge clk) disable iff (sys_rst)
        (start && !busy && opcode == `SRE_OP_RETURN && !ext_stack) |->
        ##9 (done && sp_out == $past(sp_out, 9) + 16'h0002))
        else $error("return stack pointer wrong");
    a_push_wrap: assert property (
        @(posedge clk) disable iff (sys_rst)
        (stk_req.we && $past(sp_out) == 16'h0000) |->
        stk_req.addr == 16'hFFFF)
        else $error("stack pointer wrap wrong");
    a_flags_kept: assert property (
        @(posedge clk) disable iff (sys_rst)
        (start && !busy && opcode == `SRE_OP_PUSH_INC) |->
        ##9 (flags_out == $past(flags_in, 9)))
        else $error("flags changed by push");
    a_rot_ind_len: assert property (
        @(posedge clk) disable iff (sys_rst)
        (start && !busy && opcode == `SRE_OP_ROT_IND) |-> ##5 done)
        else $error("indirect rotate length wrong");
endmodule : sre_exec

/* File: sre_mem_model.sv */
// sre_mem_model.sv: behavioural register file and system stack memory
// assumes: sre_exec drives the requests; reads answer in the same cycle
`timescale 1ns/1ns
module sre_mem_model (
    input wire logic clk, // core clock
    input wire sre_pkg::sre_rf_req_type rf_req, // register file access
    output logic [7:0] rf_rdata, // register file read data
    input wire sre_pkg::sre_stk_req_type stk_req, // stack memory access
    output logic [7:0] stk_rdata // stack memory read data
);
    logic [7:0] rf [0:255];
    logic [7:0] stk [0:65535];
    ////////////////////////////////////////////////////////////////////////
    // same-cycle reads; full sixteen bit stack address decode
    assign rf_rdata = rf[rf_req.addr];
    assign stk_rdata = stk[stk_req.addr];
    ////////////////////////////////////////////////////////////////////////
    // writes land on the rising edge, only on a clean write enable
    always @(posedge clk) begin
        if (rf_req.we === 1'b1) begin
            rf[rf_req.addr] <= rf_req.wdata;
        end
        if (stk_req.we === 1'b1) begin
            stk[stk_req.addr] <= stk_req.wdata;
        end
    end
endmodule : sre_mem_model

/* File: tb.sv */
// tb.sv: self-checking bench for the stack and rotate executer
// assumes: sre_mem_model stands in for register file and stack memory
`timescale 1ns/1ns
`include "sre_map.svh"
`define CHK(nm, ex, gt) begin \
    total_checks++; \
    if ((gt) !== (ex)) begin \
        $display("[ERR] %s expected %h seen %h", nm, ex, gt); \
        error_cnt++; \
    end \
end
module tb;
    logic clk, sys_rst, start, ext_stack, busy, done, illegal, pc_load;
    logic [7:0] opcode, op_a, op_b, rf_rdata, stk_rdata, flags_in, flags_out;
    logic [15:0] sp_out, pc_out;
    sre_pkg::sre_rf_req_type rf_req;
    sre_pkg::sre_stk_req_type stk_req;
    int error_cnt, total_checks, cyc_cnt, seed, i, k;
    logic [7:0] exp_rf [0:255];
    logic [7:0] exp_stk [logic [15:0]];
    logic [15:0] exp_sp, exp_pc;
    logic [7:0] exp_flags;
    logic [7:0] user_ops [0:6];
    logic [7:0] rot_vals [0:5];
    ////////////////////////////////////////////////////////////////////////
    // design and far-side model
    sre_exec sre_exec_i (.clk(clk), .sys_rst(sys_rst), .start(start),
        .opcode(opcode), .op_a(op_a), .op_b(op_b), .ext_stack(ext_stack),
        .busy(busy), .done(done), .illegal(illegal), .rf_req(rf_req),
        .rf_rdata(rf_rdata), .stk_req(stk_req), .stk_rdata(stk_rdata),
        .sp_out(sp_out), .pc_out(pc_out), .pc_load(pc_load),
        .flags_in(flags_in), .flags_out(flags_out));
    sre_mem_model sre_mem_model_i (.clk(clk), .rf_req(rf_req),
        .rf_rdata(rf_rdata), .stk_req(stk_req), .stk_rdata(stk_rdata));
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // expected helpers: cycle count and rotate result with flags
    function automatic int exp_cyc(input logic [7:0] op, input logic ext);
        if (op == `SRE_OP_CARRY_CLR || op == `SRE_OP_ROT_DIR ||
            op == `SRE_OP_ROT_IND) return `SRE_CYC_SHORT;
        if (op == `SRE_OP_RETURN && ext) return `SRE_CYC_RET_EXT;
        return `SRE_CYC_STACK;
    endfunction : exp_cyc
    function automatic logic [15:0] rot_exp(input logic [7:0] d,
                                            input logic [7:0] f);
        logic [7:0] r;
        logic [7:0] nf;
        r = {d[6:0], d[7]};
        nf = f;
        nf[`SRE_FLAG_C] = d[7];
        nf[`SRE_FLAG_Z] = (r == 8'h00);
        nf[`SRE_FLAG_S] = r[7];
        nf[`SRE_FLAG_V] = d[7] ^ r[7];
        return {r, nf};
    endfunction : rot_exp
    ////////////////////////////////////////////////////////////////////////
    // one instruction: drive, wait for the answer, then compare
    task automatic run_op(input logic [7:0] op, input logic [7:0] a,
                          input logic [7:0] b, input logic ext,
                          input logic hold);
        int n;
        logic pl;
        logic ill;
        logic [7:0] p;
        logic [7:0] fl;
        n = 0;
        pl = 1'b0;
        ill = 1'b0;
        fl = $random(seed);
        opcode = op;
        op_a = a;
        op_b = b;
        ext_stack = ext;
        flags_in = fl;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = hold;
        while (done !== 1'b1 && illegal !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            start = 1'b0;
            n++;
            if (pc_load === 1'b1) pl = 1'b1;
        end
        ill = (illegal === 1'b1);
        case (op)
            `SRE_OP_POP_DEC, `SRE_OP_POP_INC: begin
                p = exp_rf[b];
                exp_rf[a] = exp_rf[p];
                exp_rf[b] = (op == `SRE_OP_POP_DEC) ? p - 8'h01 : p + 8'h01;
            end
            `SRE_OP_PUSH_DEC, `SRE_OP_PUSH_INC: begin
                p = (op == `SRE_OP_PUSH_DEC) ? exp_rf[a] - 8'h01 :
                    exp_rf[a] + 8'h01;
                exp_rf[a] = p;
                exp_rf[p] = exp_rf[b];
            end
            `SRE_OP_PUSH_DIR, `SRE_OP_PUSH_IND: begin
                exp_sp = exp_sp - 16'h0001;
                p = (op == `SRE_OP_PUSH_DIR) ? exp_rf[a] : exp_rf[exp_rf[a]];
                exp_stk[exp_sp] = p;
                `CHK("stack", p, sre_mem_model_i.stk[exp_sp])
            end
            `SRE_OP_RETURN: begin
                exp_pc = {exp_stk[exp_sp], exp_stk[exp_sp + 16'h0001]};
                exp_sp = exp_sp + 16'h0002;
            end
            `SRE_OP_CARRY_CLR: fl[`SRE_FLAG_C] = 1'b0;
            `SRE_OP_ROT_DIR, `SRE_OP_ROT_IND: begin
                p = (op == `SRE_OP_ROT_DIR) ? a : exp_rf[a];
                {exp_rf[p], fl} = rot_exp(exp_rf[p], fl);
            end
            default: n = n + 100;
        endcase
        // flags_in is loaded on every taken start, refused opcodes too
        exp_flags = fl;
        if (n >= 100) begin
            `CHK("illegal", 1'b1, ill)
            `CHK("illegal_cycles", 100, n)
        end else begin
            `CHK("cycles", exp_cyc(op, ext), n)
            `CHK("done", 1'b1, done)
        end
        `CHK("flags", exp_flags, flags_out)
        `CHK("sp", exp_sp, sp_out)
        `CHK("pc", exp_pc, pc_out)
        `CHK("pc_load", (op == `SRE_OP_RETURN), pl)
        for (k = 0; k < 256; k++) begin
            `CHK("rf", exp_rf[k], sre_mem_model_i.rf[k])
        end
    endtask : run_op
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, rotate corners, random user ops, stack, refusal
    initial begin
        seed = 32'h0c41b440;
        {start, ext_stack, opcode, op_a, op_b, flags_in} = '0;
        sys_rst = 1'b1;
        error_cnt = 0;
        total_checks = 0;
        cyc_cnt = 0;
        exp_sp = `SRE_RST_WORD;
        exp_pc = `SRE_RST_WORD;
        exp_flags = `SRE_RST_BYTE;
        user_ops = '{`SRE_OP_POP_DEC, `SRE_OP_POP_INC, `SRE_OP_PUSH_DEC,
            `SRE_OP_PUSH_INC, `SRE_OP_CARRY_CLR, `SRE_OP_ROT_DIR,
            `SRE_OP_ROT_IND};
        rot_vals = '{8'h00, 8'h80, 8'hAA, 8'h40, 8'h7F, 8'hFF};
        for (i = 0; i < 256; i++) begin
            exp_rf[i] = (i < 16) ? ($random(seed) & 8'h7F) + 8'h40 :
                $random(seed);
            sre_mem_model_i.rf[i] = exp_rf[i];
        end
        repeat (8) @(posedge clk);
        #1;
        `CHK("sp_reset", `SRE_RST_WORD, sp_out)
        `CHK("pc_reset", `SRE_RST_WORD, pc_out)
        `CHK("busy_reset", 1'b0, busy)
        sys_rst = 1'b0;
        for (i = 0; i < 6; i++) begin
            exp_rf[16 + i] = rot_vals[i];
            sre_mem_model_i.rf[16 + i] = rot_vals[i];
            run_op(`SRE_OP_ROT_DIR, 16 + i, 8'h00, 1'b0, 1'b0);
        end
        $display("test rotate corners done");
        for (i = 0; i < 28; i++) begin
            k = ($random(seed) & 32'h0F);
            run_op(user_ops[i % 7],
                (user_ops[i % 7] == `SRE_OP_ROT_DIR ||
                 user_ops[i % 7] < `SRE_OP_PUSH_INC + 8'h01 &&
                 user_ops[i % 7] > `SRE_OP_PUSH_INC) ? 8'd16 + k :
                (user_ops[i % 7] >= `SRE_OP_ROT_DIR &&
                 user_ops[i % 7] != `SRE_OP_ROT_IND &&
                 user_ops[i % 7] != `SRE_OP_CARRY_CLR) ? 8'd16 + k : k,
                (user_ops[i % 7] >= `SRE_OP_ROT_DIR) ? k :
                8'd32 + ($random(seed) & 8'h0F), $random(seed),
                $random(seed));
        end
        $display("test random user ops done");
        for (i = 0; i < 2; i++) begin
            run_op(`SRE_OP_PUSH_DIR, 8'd32 + i, 8'h00, 1'b0, 1'b1);
            run_op(`SRE_OP_PUSH_IND, i, 8'h00, 1'b1, 1'b0);
            run_op(`SRE_OP_RETURN, 8'h00, 8'h00, i[0], 1'b0);
        end
        $display("test system stack done");
        run_op(8'h50, 8'h00, 8'h00, 1'b0, 1'b0);
        run_op(8'h00, 8'h01, 8'h02, 1'b1, 1'b0);
        $display("test refused opcodes done");
        summarize();
    end
endmodule : tb
